// ### hdl/pmta_table_access.sv
`timescale 1ns/1ns
// Notes on behaviour
// - The store is only written through this table access path.
// - Table reads and writes are served while the device runs normally.
// - Target address is the page register above the effective address.
// - Low-word accesses reach bits 15:0 of the program word.
// - High-part accesses reach bits 23:16 of the program word.
// - Low-word accesses work in word mode and byte mode.
// - High-part accesses work in word mode, and in byte mode at even addresses only.
module pmta_table_access #(
	parameter int ADDR_W = 14
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic page_write,
	input wire logic [7:0] page_data,
	input wire logic req_valid,
	input wire pmta_pkg::pmta_req_type req,
	output logic busy,
	output logic [7:0] program_page_select,
	output logic [23:0] target_addr,
	output pmta_pkg::pmta_rsp_type rsp
);
	// ----------------------------------------
	// Lane decode
	// ----------------------------------------
	function automatic logic [2:0] lane_mask(
		input pmta_pkg::pmta_op_type op,
		input logic byte_mode,
		input logic sel
	);
		logic [2:0] m;
		m = pmta_pkg::MASK_NONE;
		if (op == pmta_pkg::write_low_program_word) begin
			if (!byte_mode) m = pmta_pkg::MASK_LOW_WORD;
			else if (sel) m = pmta_pkg::MASK_BYTE1;
			else m = pmta_pkg::MASK_BYTE0;
		end else if (op == pmta_pkg::write_high_program_part) begin
			// Odd byte above the field does not exist
			if (!byte_mode || !sel) m = pmta_pkg::MASK_HIGH;
		end
		return m;
	endfunction

	function automatic logic [15:0] extract(
		input pmta_pkg::pmta_op_type op,
		input logic byte_mode,
		input logic sel,
		input logic [23:0] word
	);
		logic [15:0] r;
		r = pmta_pkg::DATA_RESET;
		if (op == pmta_pkg::read_low_program_word) begin
			if (!byte_mode) r = word[15:0];
			else if (sel) r[7:0] = word[15:8];
			else r[7:0] = word[7:0];
		end else if (op == pmta_pkg::read_high_program_part) begin
			// Odd high byte reads as zero
			if (!byte_mode || !sel) r[7:0] = word[23:16];
		end
		return r;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic {st_idle, st_read} pmta_state_type;

	pmta_state_type state, next_state;
	logic [7:0] next_page;
	logic next_busy;
	logic [23:0] next_target;
	pmta_pkg::pmta_rsp_type next_rsp;
	pmta_pkg::pmta_op_type op_q, next_op_q;
	logic byte_q, next_byte_q;
	logic sel_q, next_sel_q;
	logic accept;
	logic is_read;
	logic [22:0] word_index;
	logic [ADDR_W-1:0] arr_addr;
	logic [2:0] arr_we;
	logic [23:0] arr_wdata;
	logic [23:0] arr_rdata;

	assign accept = req_valid && state == st_idle;
	assign is_read = req.op == pmta_pkg::read_low_program_word ||
		req.op == pmta_pkg::read_high_program_part;
	// Even/odd byte of a word is the low address bit
	assign word_index = {program_page_select, req.ea[15:1]};
	assign arr_addr = word_index[ADDR_W-1:0];
	assign arr_we = accept ? lane_mask(req.op, req.byte_mode, req.ea[0]) :
		pmta_pkg::MASK_NONE;
	assign arr_wdata = {req.wdata[7:0],
		req.byte_mode ? req.wdata[7:0] : req.wdata[15:8],
		req.wdata[7:0]};

	pmta_array #(
		.ADDR_W(ADDR_W)
	) u_array (
		.clk(clk),
		.ce(ce),
		.addr(arr_addr),
		.byte_we(arr_we),
		.wdata(arr_wdata),
		.rdata(arr_rdata)
	);

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_page = program_page_select;
		next_target = target_addr;
		next_op_q = op_q;
		next_byte_q = byte_q;
		next_sel_q = sel_q;
		next_rsp = rsp;
		next_rsp.done = 1'b0;
		// Page write lands after any access taken this cycle
		if (page_write) begin
			next_page = page_data;
		end
		case (state)
			st_idle: begin
				if (accept) begin
					next_target = {program_page_select, req.ea};
					next_op_q = req.op;
					next_byte_q = req.byte_mode;
					next_sel_q = req.ea[0];
					if (is_read) begin
						next_state = st_read;
					end else begin
						next_rsp.done = 1'b1;
					end
				end
			end
			st_read: begin
				next_rsp.rdata = extract(op_q, byte_q, sel_q, arr_rdata);
				next_rsp.done = 1'b1;
				next_state = st_idle;
			end
			default: begin
				next_state = st_idle;
			end
		endcase
		next_busy = next_state == st_read;
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= st_idle;
			program_page_select <= pmta_pkg::PAGE_RESET;
			busy <= 1'b0;
			target_addr <= pmta_pkg::ADDR_RESET;
			op_q <= pmta_pkg::read_low_program_word;
			byte_q <= 1'b0;
			sel_q <= 1'b0;
			rsp <= '0;
		end else if (ce) begin
			state <= next_state;
			program_page_select <= next_page;
			busy <= next_busy;
			target_addr <= next_target;
			op_q <= next_op_q;
			byte_q <= next_byte_q;
			sel_q <= next_sel_q;
			rsp <= next_rsp;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// Frozen cycles are excluded; checks assume ce stays high
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn || !ce);

	a_addr_form: assert property (accept |=>
		target_addr == {$past(program_page_select), $past(req.ea)})
		else $error("target address not page over ea");
	a_page_load: assert property (page_write |=>
		program_page_select == $past(page_data))
		else $error("page register not loaded");
	a_read_done: assert property (accept && is_read |=>
		busy && !rsp.done ##1 rsp.done && !busy)
		else $error("read did not finish in two cycles");
	a_write_done: assert property (accept && !is_read |=>
		rsp.done && !busy)
		else $error("write not acknowledged next cycle");
	a_low_word_rd: assert property (state == st_read &&
		op_q == pmta_pkg::read_low_program_word && !byte_q |=>
		rsp.rdata == $past(arr_rdata[15:0]))
		else $error("low word read wrong");
	a_low_byte_rd: assert property (state == st_read &&
		op_q == pmta_pkg::read_low_program_word && byte_q |=>
		rsp.rdata == {8'h00, sel_q ? $past(arr_rdata[15:8]) :
		$past(arr_rdata[7:0])})
		else $error("low byte read wrong");
	a_high_word_rd: assert property (state == st_read &&
		op_q == pmta_pkg::read_high_program_part && !byte_q |=>
		rsp.rdata == {8'h00, $past(arr_rdata[23:16])})
		else $error("high word read wrong");
	a_high_odd_rd: assert property (state == st_read &&
		op_q == pmta_pkg::read_high_program_part && byte_q && sel_q |=>
		rsp.rdata == 16'h0000)
		else $error("odd high byte not zero");
	a_high_lane_wr: assert property (accept &&
		req.op == pmta_pkg::write_high_program_part |->
		arr_we == ((req.byte_mode && req.ea[0]) ? 3'h0 : 3'h4))
		else $error("high write lane wrong");
	a_low_lane_wr: assert property (accept &&
		req.op == pmta_pkg::write_low_program_word |->
		arr_we == (!req.byte_mode ? 3'h3 : (req.ea[0] ? 3'h2 : 3'h1)))
		else $error("low write lane wrong");

	c_read_high: cover property (accept &&
		req.op == pmta_pkg::read_high_program_part ##2 rsp.done);
	c_write_low_byte: cover property (accept && req.byte_mode &&
		req.op == pmta_pkg::write_low_program_word);
	c_back_to_back: cover property (rsp.done && accept);
endmodule // pmta_table_access

// ### inc/pmta_pkg.sv
// ----------------------------------------
// Shared constants and carriers
// ----------------------------------------
package pmta_pkg;
	localparam int PAGE_W = 8;
	localparam int EA_W = 16;
	localparam int WORD_W = 24;
	localparam int DATA_W = 16;
	localparam int LANES = 3;
	localparam int LOW_LSB = 0;
	localparam int LOW_MSB = 15;
	localparam int HIGH_LSB = 16;
	localparam int HIGH_MSB = 23;
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [15:0] DATA_RESET = 16'h0000;
	localparam logic [23:0] ADDR_RESET = 24'h000000;
	localparam logic [2:0] MASK_NONE = 3'h0;
	localparam logic [2:0] MASK_LOW_WORD = 3'h3;
	localparam logic [2:0] MASK_BYTE0 = 3'h1;
	localparam logic [2:0] MASK_BYTE1 = 3'h2;
	localparam logic [2:0] MASK_HIGH = 3'h4;

	typedef enum logic [1:0] {
		read_low_program_word,
		write_low_program_word,
		read_high_program_part,
		write_high_program_part
	} pmta_op_type;

	typedef struct packed {
		pmta_op_type op;
		logic byte_mode;
		logic [15:0] ea;
		logic [15:0] wdata;
	} pmta_req_type;

	typedef struct packed {
		logic done;
		logic [15:0] rdata;
	} pmta_rsp_type;
endpackage

// ### hdl/pmta_array.sv
`timescale 1ns/1ns
// ----------------------------------------
// Program word store, byte-lane writes
// ----------------------------------------
module pmta_array #(
	parameter int ADDR_W = 14
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [2:0] byte_we,
	input wire logic [23:0] wdata,
	output logic [23:0] rdata
);
	logic [23:0] mem [0:(1<<ADDR_W)-1];

	// No reset on contents; read is one clock late
	always_ff @(posedge clk) begin
		if (ce) begin
			for (int b = 0; b < pmta_pkg::LANES; b++) begin
				if (byte_we[b]) begin
					mem[addr][8*b +: 8] <= wdata[8*b +: 8];
				end
			end
			rdata <= mem[addr];
		end
	end
endmodule // pmta_array

// ### bench/pmta_core_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Core side issuing table accesses
// ----------------------------------------
module pmta_core_model (
	input wire logic clk,
	input wire logic busy,
	input wire pmta_pkg::pmta_rsp_type rsp,
	output logic ce,
	output logic page_write,
	output logic [7:0] page_data,
	output logic req_valid,
	output pmta_pkg::pmta_req_type req
);
	initial begin
		ce = 1'b1;
		page_write = 1'b0;
		page_data = 8'h00;
		req_valid = 1'b0;
		req = '0;
	end
	task automatic set_page(input logic [7:0] p);
		@(negedge clk);
		page_write = 1'b1;
		page_data = p;
		@(negedge clk);
		page_write = 1'b0;
		page_data = ~p;
	endtask
	// Everything offered while frozen must be lost
	task automatic freeze(input int n);
		@(negedge clk);
		ce = 1'b0;
		page_write = 1'b1;
		page_data = 8'h77;
		req_valid = 1'b1;
		req.op = pmta_pkg::write_low_program_word;
		req.byte_mode = 1'b0;
		req.ea = 16'h0010;
		req.wdata = 16'h1111;
		repeat (n) @(negedge clk);
		page_write = 1'b0;
		req_valid = 1'b0;
		ce = 1'b1;
	endtask
	// Sole path to the store, in normal run
	task automatic access(input pmta_pkg::pmta_op_type op, input logic bm,
		input logic [15:0] ea, input logic [15:0] wd,
		output logic [15:0] rd, output logic ok, output logic bz,
		output int waits);
		ok = 1'b0;
		rd = 16'h0000;
		bz = 1'b0;
		waits = 0;
		@(negedge clk);
		req_valid = 1'b1;
		req.op = op;
		req.byte_mode = bm;
		req.ea = ea;
		req.wdata = wd;
		// Busy is low here: the previous access was waited out
		@(posedge clk);
		@(negedge clk);
		req_valid = 1'b0;
		req.ea = ~ea;
		req.wdata = ~wd;
		bz = busy;
		for (int i = 0; i < 4 && !ok; i++) begin
			if (rsp.done === 1'b1) begin
				ok = 1'b1;
				rd = rsp.rdata;
			end else begin
				waits++;
				@(negedge clk);
			end
		end
	endtask
endmodule // pmta_core_model

// ### bench/tb.sv
`timescale 1ns/1ns
`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin \
	n_errors++; $display("BAD %0t %s", $time, m); end end
module tb;
	logic clk, rstn, ok, bz;
	logic [15:0] rd;
	wire logic busy, ce, page_write, req_valid;
	wire logic [7:0] page_data, pps;
	wire logic [23:0] target;
	wire pmta_pkg::pmta_req_type req;
	wire pmta_pkg::pmta_rsp_type rsp;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	pmta_table_access #(.ADDR_W(6)) u_pmta_table_access (.clk(clk),
		.rstn(rstn), .ce(ce), .page_write(page_write),
		.page_data(page_data), .req_valid(req_valid), .req(req),
		.busy(busy), .program_page_select(pps), .target_addr(target),
		.rsp(rsp));
	pmta_core_model u_core (.clk(clk), .busy(busy), .rsp(rsp), .ce(ce),
		.page_write(page_write), .page_data(page_data),
		.req_valid(req_valid), .req(req));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic give_verdict();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Far too long for the fewer than a hundred cycles the tests need
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_errors++;
			give_verdict();
		end
	end
	task automatic acc(input pmta_pkg::pmta_op_type op, input logic bm,
		input logic [15:0] ea, input logic [15:0] wd);
		logic rdop;
		int waits;
		rdop = op == pmta_pkg::read_low_program_word ||
			op == pmta_pkg::read_high_program_part;
		u_core.access(op, bm, ea, wd, rd, ok, bz, waits);
		`CHK(ok, 1'b1, "no done");
		`CHK(bz, rdop, "busy wrong");
		`CHK(waits, (rdop ? 1 : 0), "answer late");
	endtask
	task automatic t_reset();
		`CHK({busy, pps, target, rsp}, 50'h0, "reset state");
		$display("t_reset done");
	endtask
	task automatic t_addr();
		u_core.set_page(8'ha5);
		`CHK(pps, 8'ha5, "page");
		acc(pmta_pkg::write_low_program_word, 1'b0, 16'h1234, 16'h0000);
		`CHK(target, 24'ha51234, "target write");
		u_core.set_page(8'h3c);
		acc(pmta_pkg::write_high_program_part, 1'b0, 16'hfffe, 16'h00a7);
		acc(pmta_pkg::read_high_program_part, 1'b0, 16'hfffe, 16'h0000);
		`CHK(target, 24'h3cfffe, "target read");
		`CHK(rd, 16'h00a7, "top word");
		$display("t_addr done");
	endtask
	task automatic t_word();
		acc(pmta_pkg::write_low_program_word, 1'b0, 16'h0010, 16'hbeef);
		acc(pmta_pkg::write_high_program_part, 1'b0, 16'h0010, 16'hff7c);
		acc(pmta_pkg::read_low_program_word, 1'b0, 16'h0010, 16'h0000);
		`CHK(rd, 16'hbeef, "low word");
		acc(pmta_pkg::read_high_program_part, 1'b0, 16'h0010, 16'h0000);
		`CHK(rd, 16'h007c, "high word");
		$display("t_word done");
	endtask
	task automatic t_byte();
		acc(pmta_pkg::write_low_program_word, 1'b1, 16'h0020, 16'hff11);
		acc(pmta_pkg::write_low_program_word, 1'b1, 16'h0021, 16'hff22);
		acc(pmta_pkg::read_low_program_word, 1'b0, 16'h0020, 16'h0000);
		`CHK(rd, 16'h2211, "low bytes");
		acc(pmta_pkg::read_low_program_word, 1'b1, 16'h0021, 16'h0000);
		`CHK(rd, 16'h0022, "low byte1");
		acc(pmta_pkg::read_low_program_word, 1'b1, 16'h0020, 16'h0000);
		`CHK(rd, 16'h0011, "low byte0");
		acc(pmta_pkg::write_high_program_part, 1'b1, 16'h0020, 16'hff5a);
		acc(pmta_pkg::write_high_program_part, 1'b1, 16'h0021, 16'hff99);
		acc(pmta_pkg::read_high_program_part, 1'b0, 16'h0020, 16'h0000);
		`CHK(rd, 16'h005a, "high byte");
		acc(pmta_pkg::read_high_program_part, 1'b1, 16'h0020, 16'h0000);
		`CHK(rd, 16'h005a, "even high byte");
		acc(pmta_pkg::read_high_program_part, 1'b1, 16'h0021, 16'h0000);
		`CHK(rd, 16'h0000, "odd high byte");
		acc(pmta_pkg::read_low_program_word, 1'b0, 16'h0020, 16'h0000);
		`CHK(rd, 16'h2211, "low kept");
		$display("t_byte done");
	endtask
	task automatic t_freeze();
		u_core.freeze(4);
		`CHK(pps, 8'h3c, "page frozen");
		`CHK(target, 24'h3c0020, "target frozen");
		`CHK(rsp.done, 1'b0, "done frozen");
		acc(pmta_pkg::read_low_program_word, 1'b0, 16'h0010, 16'h0000);
		`CHK(rd, 16'hbeef, "store frozen");
		$display("t_freeze done");
	endtask
	initial begin
		rstn = 1'b0;
		repeat (6) @(negedge clk);
		t_reset();
		rstn = 1'b1;
		t_addr();
		t_word();
		t_byte();
		t_freeze();
		give_verdict();
	end
endmodule // tb
